// ===== common/fweg_map.svh
// Purpose: Register addresses, field positions, key codes and reset values
// Assumes: Special-function-register bus with 8-bit addresses and pages
// Notes:   Definitions only
`ifndef FWEG_MAP_SVH
`define FWEG_MAP_SVH

// ==========================================================================
// Register map
`define FWEG_PSC_ADDR      8'h8f
`define FWEG_PSC_PAGE      8'h00
`define FWEG_KEY_ADDR      8'hb7
`define FWEG_PSC_RESET     2'h0

// ==========================================================================
// Field positions
`define FWEG_WE_BIT        0
`define FWEG_EE_BIT        1
`define FWEG_UPPER_ZERO    6'h00

// ==========================================================================
// Key codes and lock-state readback codes
`define FWEG_KEY_FIRST     8'ha5
`define FWEG_KEY_SECOND    8'hf1
`define FWEG_CODE_LOCKED   2'h0
`define FWEG_CODE_FIRST    2'h1
`define FWEG_CODE_OPEN     2'h2
`define FWEG_CODE_DISABLED 2'h3
`define FWEG_ERASE_DATA    8'h00
`define FWEG_RDATA_RESET   8'h00
`define FWEG_XADDR_W       16

`endif

// ===== common/fweg_pkg.sv
// Purpose: Types shared by the flash write/erase gate
// Assumes: fweg_map.svh supplies the external address width
// Notes:   Structs carry grouped bus signals
`include "fweg_map.svh"

package fweg_pkg;

    // ======================================================================
    // Lock state, one-hot
    typedef enum logic [3:0] {
        FWEG_LOCKED   = 4'h1,
        FWEG_FIRST    = 4'h2,
        FWEG_OPEN     = 4'h4,
        FWEG_DISABLED = 4'h8
    } fweg_lock_t;

    // ======================================================================
    // Bus carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] page;
        logic [7:0] wdata;
    } fweg_sfr_req_t;

    typedef struct packed {
        logic                       wr;
        logic [`FWEG_XADDR_W-1:0]   addr;
        logic [7:0]                 data;
    } fweg_xdata_t;

    typedef struct packed {
        logic                       prog;
        logic                       erase;
        logic [`FWEG_XADDR_W-1:0]   addr;
        logic [7:0]                 data;
    } fweg_flash_cmd_t;

endpackage

// ===== hw/fweg_gate.sv
// Purpose: Steers external-data writes to flash program or page erase,
//          guarded by enable bits and a two-step lock-and-key register
// Assumes: Inputs synchronous to clock; flash_done pulses once per operation
// Notes:   One operation per unlock; misuse locks out until sys_rst
//
// Overview of operation
// - Control register bits 7:2 always read zero and writes to them are dropped.
// - With erase and write enables set, an external-data write erases the addressed page.
// - The data byte of an erasing external-data write is ignored.
// - With write enable set and erase enable clear, an external-data write programs one byte.
// - While write enable is set, external-data writes go to flash instead of data space.
// - Byte writes are blocked with write enable clear, erasure with erase enable clear.
// - Writes and erases are permitted only after key 0xa5 then key 0xf1 is written.
// - Permission is revoked when the next single flash operation completes.
// - A key write that breaks the sequence locks flash out until device reset.
// - A flash operation attempted without permission also locks flash out until reset.
// - Writing any value but the first key from the locked state forces the lockout.
// - Key register reads return lock state in bits 1:0: locked, first, open, disabled.
// - The key register decodes at its address on every register page.
// - The control register decodes at its address only while page zero is selected.
`timescale 1ns/10ps
`include "fweg_map.svh"

module fweg_gate (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    // Special-function-register bus
    input  wire fweg_pkg::fweg_sfr_req_t   sfr_req,
    output      logic [7:0]                sfr_rdata,
    // External-data write cycles from the core
    input  wire fweg_pkg::fweg_xdata_t     xdata_req,
    // Flash array
    output      fweg_pkg::fweg_flash_cmd_t flash_cmd,
    input  wire logic                      flash_done,
    // External data memory
    output      fweg_pkg::fweg_xdata_t     xram_cmd
);
    import fweg_pkg::*;

    // ======================================================================
    // Decode helpers
    function automatic logic [1:0] lock_code(input fweg_lock_t st);
        case (st)
            FWEG_FIRST:    lock_code = `FWEG_CODE_FIRST;
            FWEG_OPEN:     lock_code = `FWEG_CODE_OPEN;
            FWEG_DISABLED: lock_code = `FWEG_CODE_DISABLED;
            default:       lock_code = `FWEG_CODE_LOCKED;
        endcase
    endfunction

    function automatic logic psc_hit(input fweg_sfr_req_t r);
        psc_hit = (r.addr == `FWEG_PSC_ADDR) && (r.page == `FWEG_PSC_PAGE);
    endfunction

    function automatic logic key_hit(input fweg_sfr_req_t r);
        key_hit = (r.addr == `FWEG_KEY_ADDR);
    endfunction

    // ======================================================================
    // State
    logic       write_enable;
    logic       erase_enable;
    logic       busy;
    fweg_lock_t lock_state;
    fweg_lock_t next_lock;

    logic psc_wr;
    logic key_wr;
    logic flash_try;
    logic flash_ok;

    assign psc_wr    = sfr_req.wr && psc_hit(sfr_req);
    assign key_wr    = sfr_req.wr && key_hit(sfr_req);
    assign flash_try = xdata_req.wr && write_enable;
    // Busy counts as no permission: the single grant is already in use
    assign flash_ok  = flash_try && (lock_state == FWEG_OPEN) && !busy;

    // ======================================================================
    // Program-store control register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {erase_enable, write_enable} <= `FWEG_PSC_RESET;
        end else if (psc_wr) begin
            // Upper six bits have no storage at all
            write_enable <= sfr_req.wdata[`FWEG_WE_BIT];
            erase_enable <= sfr_req.wdata[`FWEG_EE_BIT];
        end
    end

    // ======================================================================
    // Lock-and-key state machine
    always_comb begin
        next_lock = lock_state;
        case (lock_state)
            FWEG_LOCKED: begin
                // A try beats a same-cycle key write: never permitted here
                if (flash_try) begin
                    next_lock = FWEG_DISABLED;
                end else if (key_wr) begin
                    if (sfr_req.wdata == `FWEG_KEY_FIRST) begin
                        next_lock = FWEG_FIRST;
                    end else begin
                        next_lock = FWEG_DISABLED;
                    end
                end
            end
            FWEG_FIRST: begin
                if (flash_try) begin
                    next_lock = FWEG_DISABLED;
                end else if (key_wr) begin
                    if (sfr_req.wdata == `FWEG_KEY_SECOND) begin
                        next_lock = FWEG_OPEN;
                    end else begin
                        next_lock = FWEG_DISABLED;
                    end
                end
            end
            FWEG_OPEN: begin
                if (key_wr) begin
                    next_lock = FWEG_DISABLED;
                end else if (flash_try && busy) begin
                    next_lock = FWEG_DISABLED;
                end else if (busy && flash_done) begin
                    next_lock = FWEG_LOCKED;
                end
            end
            default: begin
                // Only sys_rst leaves this state
                next_lock = FWEG_DISABLED;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lock_state <= FWEG_LOCKED;
        end else begin
            lock_state <= next_lock;
        end
    end

    // ======================================================================
    // Operation in flight, closed by the flash array
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else if (flash_ok) begin
            busy <= 1'b1;
        end else if (flash_done) begin
            busy <= 1'b0;
        end
    end

    // ======================================================================
    // Flash command issue
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flash_cmd <= '0;
        end else begin
            flash_cmd.prog  <= flash_ok && !erase_enable;
            flash_cmd.erase <= flash_ok && erase_enable;
            flash_cmd.addr  <= xdata_req.addr;
            // Erase selects by address only; data is forced quiet
            flash_cmd.data  <= erase_enable ? `FWEG_ERASE_DATA : xdata_req.data;
        end
    end

    // ======================================================================
    // Normal data-space path
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            xram_cmd <= '0;
        end else begin
            xram_cmd.wr   <= xdata_req.wr && !write_enable;
            xram_cmd.addr <= xdata_req.addr;
            xram_cmd.data <= xdata_req.data;
        end
    end

    // ======================================================================
    // Register readback, one cycle after the read strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sfr_rdata <= `FWEG_RDATA_RESET;
        end else if (sfr_req.rd) begin
            if (psc_hit(sfr_req)) begin
                sfr_rdata <= {`FWEG_UPPER_ZERO, erase_enable, write_enable};
            end else if (key_hit(sfr_req)) begin
                sfr_rdata <= {`FWEG_UPPER_ZERO, lock_code(lock_state)};
            end else begin
                sfr_rdata <= `FWEG_RDATA_RESET;
            end
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence seq_key_first;
        key_wr && sfr_req.wdata == `FWEG_KEY_FIRST && lock_state == FWEG_LOCKED;
    endsequence

    sequence seq_key_second;
        key_wr && sfr_req.wdata == `FWEG_KEY_SECOND && lock_state == FWEG_FIRST;
    endsequence

    sequence seq_flash_erase_req;
        flash_ok && erase_enable;
    endsequence

    chk_ctrl_upper_zero: assert property (
        sfr_req.rd && psc_hit(sfr_req) |=> sfr_rdata[7:2] == `FWEG_UPPER_ZERO)
        else $error("control register upper bits not zero");

    chk_erase_issue: assert property (
        seq_flash_erase_req |=> flash_cmd.erase && !flash_cmd.prog
            && flash_cmd.addr == $past(xdata_req.addr))
        else $error("page erase not issued");

    chk_erase_data_quiet: assert property (
        flash_cmd.erase |-> flash_cmd.data == `FWEG_ERASE_DATA)
        else $error("erase carried a data byte");

    chk_prog_issue: assert property (
        flash_ok && !erase_enable |=> flash_cmd.prog
            && flash_cmd.data == $past(xdata_req.data))
        else $error("byte program not issued");

    chk_route_flash: assert property (
        xdata_req.wr && write_enable |=> !xram_cmd.wr)
        else $error("flash-bound write leaked to data space");

    chk_blocked_op: assert property (
        !write_enable |=> !flash_cmd.prog && !flash_cmd.erase)
        else $error("flash operation without write enable");

    chk_key_sequence: assert property (
        seq_key_first ##1 seq_key_second |=> lock_state == FWEG_OPEN)
        else $error("key sequence did not unlock");

    chk_relock_done: assert property (
        lock_state == FWEG_OPEN && busy && flash_done && !key_wr && !flash_try
            |=> lock_state == FWEG_LOCKED)
        else $error("no relock after operation");

    chk_bad_key: assert property (
        key_wr && lock_state == FWEG_FIRST && sfr_req.wdata != `FWEG_KEY_SECOND
            |=> lock_state == FWEG_DISABLED [*4])
        else $error("broken key sequence not locked out");

    chk_lockout_sticky: assert property (
        lock_state == FWEG_DISABLED |=> lock_state == FWEG_DISABLED)
        else $error("lockout left without reset");

    chk_illegal_try: assert property (
        flash_try && lock_state != FWEG_OPEN
            |=> lock_state == FWEG_DISABLED && !flash_cmd.prog && !flash_cmd.erase)
        else $error("unpermitted attempt not locked out");

    chk_wrong_first: assert property (
        key_wr && lock_state == FWEG_LOCKED && sfr_req.wdata != `FWEG_KEY_FIRST
            |=> lock_state == FWEG_DISABLED)
        else $error("wrong first key not locked out");

    chk_key_readback: assert property (
        sfr_req.rd && key_hit(sfr_req) |=> sfr_rdata == {`FWEG_UPPER_ZERO,
            lock_code($past(lock_state))})
        else $error("lock state readback wrong");

    chk_ctrl_page: assert property (
        sfr_req.wr && sfr_req.addr == `FWEG_PSC_ADDR && sfr_req.page != `FWEG_PSC_PAGE
            |=> $stable(write_enable) && $stable(erase_enable))
        else $error("control register written off page zero");

    chk_xram_pass: assert property (
        xdata_req.wr && !write_enable |=> xram_cmd.wr
            && xram_cmd.addr == $past(xdata_req.addr) && $stable(lock_state))
        else $error("data-space write disturbed");

    chk_xram_data: assert property (
        xdata_req.wr && !write_enable |=> xram_cmd.data == $past(xdata_req.data))
        else $error("data-space write data wrong");

    chk_key_first: assert property (
        key_wr && sfr_req.wdata == `FWEG_KEY_FIRST && lock_state == FWEG_LOCKED
            && !flash_try |=> lock_state == FWEG_FIRST)
        else $error("first key not taken");

    chk_open_path: assert property (
        lock_state != FWEG_OPEN && next_lock == FWEG_OPEN |-> seq_key_second)
        else $error("unlocked without the key sequence");

    chk_busy_lockout: assert property (
        flash_try && busy |=> lock_state == FWEG_DISABLED && !flash_cmd.prog
            && !flash_cmd.erase)
        else $error("second attempt in flight not locked out");

    chk_one_pulse: assert property (
        flash_cmd.prog || flash_cmd.erase |=> !flash_cmd.prog && !flash_cmd.erase)
        else $error("more than one operation per unlock");

    chk_cmd_exclusive: assert property (
        !(flash_cmd.prog && flash_cmd.erase))
        else $error("program and erase issued together");

endmodule // fweg_gate

// ===== testbench/fweg_gate_tb.sv
// Purpose: Self-checking bench for the flash write/erase gate
// Assumes: Inputs driven on the falling edge; registered outputs sampled a half cycle later
// Notes:   Register table first, then hand-written key, flash and lockout cases
`timescale 1ns/10ps

module fweg_gate_tb;
    import fweg_pkg::*;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] page;
        logic [7:0] data;
    } fweg_row_t;

    // ======================================================================
    // Stimulus and observed signals
    logic            clock      = 1'b0;
    logic            sys_rst    = 1'b1;
    fweg_sfr_req_t   sfr_req    = '0;
    logic [7:0]      sfr_rdata;
    fweg_xdata_t     xdata_req  = '0;
    fweg_flash_cmd_t flash_cmd;
    logic            flash_done = 1'b0;
    fweg_xdata_t     xram_cmd;
    int              n_errors     = 0;
    int              total_checks = 0;

    // Write rows are followed by read rows that expect the stored value
    fweg_row_t rows [9] = '{
        '{1'b1, 8'h8f, 8'h00, 8'hff}, '{1'b0, 8'h8f, 8'h00, 8'h03},
        '{1'b0, 8'h8f, 8'h05, 8'h00}, '{1'b1, 8'h8f, 8'h05, 8'h00},
        '{1'b0, 8'h8f, 8'h00, 8'h03}, '{1'b0, 8'hb7, 8'h0f, 8'h00},
        '{1'b0, 8'h55, 8'h00, 8'h00}, '{1'b1, 8'h8f, 8'h00, 8'h00},
        '{1'b0, 8'h8f, 8'h00, 8'h00}
    };

    always #25 clock = ~clock;

    fweg_gate fweg_gate_i (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .sfr_req    (sfr_req),
        .sfr_rdata  (sfr_rdata),
        .xdata_req  (xdata_req),
        .flash_cmd  (flash_cmd),
        .flash_done (flash_done),
        .xram_cmd   (xram_cmd)
    );

    // ======================================================================
    // Reporting
    task automatic fail(string what);
        n_errors++;
        $display("wrong value at %0t: %s", $time, what);
    endtask

    task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
        total_checks++;
        if (got !== exp) fail($sformatf("read data %h, expected %h", got, exp));
    endtask

    // Address and data only matter while a strobe is expected
    task automatic chk_flash(fweg_flash_cmd_t exp);
        total_checks++;
        if ({flash_cmd.prog, flash_cmd.erase} !== {exp.prog, exp.erase} ||
            ((exp.prog || exp.erase) &&
             {flash_cmd.addr, flash_cmd.data} !== {exp.addr, exp.data})) fail("flash command");
    endtask

    task automatic chk_xram(fweg_xdata_t exp);
        total_checks++;
        if (xram_cmd.wr !== exp.wr ||
            (exp.wr && {xram_cmd.addr, xram_cmd.data} !== {exp.addr, exp.data})) fail("xram write");
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ======================================================================
    // Bus tasks, entered and left on a falling edge
    // One idle cycle after each, so a strobe never drops and rises in one step
    task automatic sfr_wr(logic [7:0] addr, logic [7:0] page, logic [7:0] data);
        sfr_req = '{1'b1, 1'b0, addr, page, data};
        @(negedge clock);
        sfr_req.wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic sfr_rd(logic [7:0] addr, logic [7:0] page, logic [7:0] exp);
        sfr_req = '{1'b0, 1'b1, addr, page, 8'h00};
        @(negedge clock);
        sfr_req.rd = 1'b0;
        chk_byte(sfr_rdata, exp);
        @(negedge clock);
    endtask

    // Two key writes on consecutive edges, strobe held high between them
    task automatic sfr_keys(logic [7:0] page, logic [7:0] k1, logic [7:0] k2);
        sfr_req = '{1'b1, 1'b0, 8'hb7, page, k1};
        @(negedge clock);
        sfr_req.wdata = k2;
        @(negedge clock);
        sfr_req.wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic key_is(logic [1:0] code);
        sfr_rd(8'hb7, 8'h00, {6'h00, code});
    endtask

    // Result pulses must last exactly one cycle
    task automatic x_wr(logic [15:0] addr, logic [7:0] data,
                        fweg_flash_cmd_t ef, fweg_xdata_t ex);
        xdata_req = '{1'b1, addr, data};
        @(negedge clock);
        xdata_req.wr = 1'b0;
        chk_flash(ef);
        chk_xram(ex);
        @(negedge clock);
        chk_flash('0);
        chk_xram('0);
    endtask

    task automatic pulse_done();
        flash_done = 1'b1;
        @(negedge clock);
        flash_done = 1'b0;
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
    endtask

    // ======================================================================
    // Watchdog, over forty times the expected run length
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        $display("wrong value at %0t: run hung", $time);
        test_done();
    end

    // ======================================================================
    // Main sequence
    initial begin
        do_reset();
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                sfr_wr(rows[i].addr, rows[i].page, rows[i].data);
            end else begin
                sfr_rd(rows[i].addr, rows[i].page, rows[i].data);
            end
        end
        $display("register table done");

        // Plain data-space write leaves the lock alone
        x_wr(16'h0100, 8'h3c, '0, '{1'b1, 16'h0100, 8'h3c});
        sfr_wr(8'h8f, 8'h00, 8'h02);
        x_wr(16'h0200, 8'h11, '0, '{1'b1, 16'h0200, 8'h11});
        key_is(2'h0);
        $display("data space test done");

        // Unlock from another page, erase first, relock on completion
        sfr_wr(8'hb7, 8'h0f, 8'ha5);
        key_is(2'h1);
        sfr_wr(8'hb7, 8'h0f, 8'hf1);
        key_is(2'h2);
        sfr_wr(8'h8f, 8'h00, 8'h03);
        x_wr(16'h1234, 8'h77, '{1'b0, 1'b1, 16'h1234, 8'h00}, '0);
        pulse_done();
        key_is(2'h0);
        $display("page erase test done");

        // Program the erased byte; a try after the relock locks out
        sfr_keys(8'h00, 8'ha5, 8'hf1);
        sfr_wr(8'h8f, 8'h00, 8'h01);
        x_wr(16'h1234, 8'h5a, '{1'b1, 1'b0, 16'h1234, 8'h5a}, '0);
        pulse_done();
        key_is(2'h0);
        x_wr(16'h1235, 8'h66, '0, '0);
        key_is(2'h3);
        $display("byte program test done");

        // Mid-run reset clears the lockout and the control bits
        do_reset();
        key_is(2'h0);
        sfr_rd(8'h8f, 8'h00, 8'h00);
        $display("reset test done");

        // Broken key sequences lock out until reset
        sfr_keys(8'h00, 8'ha5, 8'h00);
        key_is(2'h3);
        sfr_keys(8'h00, 8'ha5, 8'hf1);
        key_is(2'h3);
        do_reset();
        sfr_wr(8'hb7, 8'h00, 8'h12);
        key_is(2'h3);
        do_reset();
        sfr_keys(8'h00, 8'ha5, 8'hf1);
        sfr_wr(8'hb7, 8'h00, 8'ha5);
        key_is(2'h3);
        sfr_wr(8'h8f, 8'h00, 8'h01);
        x_wr(16'h0040, 8'h01, '0, '0);

        // A second try while the first is still in flight
        do_reset();
        sfr_keys(8'h00, 8'ha5, 8'hf1);
        sfr_wr(8'h8f, 8'h00, 8'h03);
        x_wr(16'h0300, 8'h21, '{1'b0, 1'b1, 16'h0300, 8'h00}, '0);
        x_wr(16'h0301, 8'h22, '0, '0);
        pulse_done();
        key_is(2'h3);
        $display("lockout test done");

        test_done();
    end

endmodule // fweg_gate_tb
